/* File: rtl/asp_fifo2.sv */
`timescale 1ns/1ps
`default_nettype none

module asp_fifo2 (
    input  wire logic                mclk,
    input  wire logic                nrst,
    input  wire logic                in_valid,
    output logic                     in_ready,
    input  wire asp_pkg::asp_stereo_s in_data,
    output logic                     out_valid,
    input  wire logic                out_ready,
    output asp_pkg::asp_stereo_s     out_data
);
    import asp_pkg::*;

    asp_stereo_s mem [2];
    logic        wr_ptr;
    logic        rd_ptr;
    logic [1:0]  count;
    logic        push;
    logic        pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= 2'(count + {1'b0, push} - {1'b0, pop});
        end
    end

    property p_fifo_no_overfill;
        @(posedge mclk) disable iff (!nrst)
        (count == 2'h2) && !pop |=> (count == 2'h2) && !in_ready;
    endproperty
    a_fifo_no_overfill: assert property (p_fifo_no_overfill)
        else $error("buffer lost its full state");

endmodule : asp_fifo2

`default_nettype wire

/* File: rtl/asp_pkg.sv */
package asp_pkg;

    typedef struct packed {
        logic [15:0] left;
        logic [15:0] right;
    } asp_stereo_s;

    localparam int          WORD_BITS      = 16;
    localparam logic [4:0]  WORD_BITS_C    = 5'(WORD_BITS);
    localparam logic [4:0]  WORD_LAST_C    = 5'(WORD_BITS - 1);

    localparam int          MCLK_HZ        = 50_000_000;
    localparam int          FS_48K_HZ      = 48_000;
    localparam int          FS_44K_HZ      = 44_100;
    localparam int          BITS_NARROW    = 32;
    localparam int          BITS_WIDE      = 50;
    localparam int          SLAVE_BCLK_MAX_HZ = 3_072_000;

    // fractional divider: half-period ticks at 2*fbclk = mclk * N / M
    localparam int          DIV_UNIT_HZ    = 100;
    localparam logic [19:0] DIV_DEN        = 20'(MCLK_HZ / DIV_UNIT_HZ);
    localparam logic [19:0] DIV_N_48_NARROW =
        20'(2 * FS_48K_HZ * BITS_NARROW / DIV_UNIT_HZ);
    localparam logic [19:0] DIV_N_48_WIDE  =
        20'(2 * FS_48K_HZ * BITS_WIDE / DIV_UNIT_HZ);
    localparam logic [19:0] DIV_N_44_NARROW =
        20'(2 * FS_44K_HZ * BITS_NARROW / DIV_UNIT_HZ);
    localparam logic [19:0] DIV_N_44_WIDE  =
        20'(2 * FS_44K_HZ * BITS_WIDE / DIV_UNIT_HZ);

    localparam logic [5:0]  HALF_NARROW    = 6'(BITS_NARROW / 2);
    localparam logic [5:0]  HALF_WIDE      = 6'(BITS_WIDE / 2);
    localparam logic [5:0]  LAST_NARROW    = 6'(BITS_NARROW - 1);
    localparam logic [5:0]  LAST_WIDE      = 6'(BITS_WIDE - 1);

    // least phase of the generated clock, percent of period
    localparam int          DUTY_MIN_PCT   = 35;
    localparam int          FAST_BCLK_HZ   = FS_48K_HZ * BITS_WIDE;
    localparam logic [7:0]  PHASE_MIN_CYC  = 8'((DUTY_MIN_PCT * MCLK_HZ
        + 100 * FAST_BCLK_HZ - 1) / (100 * FAST_BCLK_HZ));

    localparam logic [4:0]  RX_IDLE_CNT    = 5'(WORD_BITS);

endpackage : asp_pkg

/* File: rtl/asp_port.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - master drives clock and select; data out always
// - sixteen bits per channel word, msb first
// - sample msb aligned to word msb
// - msb one bit after select change, falling
// - left while select low, right high
// - master clock 32 or 50 bits per frame
// - master clock from fractional N/M divider
// - slave accepts external clock to 3.072 MHz
// - generated clock phases each at least 0.35T
// - exactly two channels, sixteen-bit samples
// - sample rate 44.1 kHz or 48 kHz
module asp_port (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 cfg_master,
    input  wire logic                 cfg_rate_44k,
    input  wire logic                 cfg_wide_frame,
    input  wire logic                 audio_bit_clock_in,
    output logic                      audio_bit_clock_out,
    output logic                      audio_bit_clock_oe,
    input  wire logic                 audio_word_select_in,
    output logic                      audio_word_select_out,
    output logic                      audio_word_select_oe,
    output logic                      audio_serial_out,
    input  wire logic                 audio_serial_in,
    input  wire logic                 tx_valid,
    output logic                      tx_ready,
    input  wire asp_pkg::asp_stereo_s tx_data,
    output logic                      tx_underrun,
    output logic                      rx_valid,
    output asp_pkg::asp_stereo_s      rx_data
);
    import asp_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    logic [19:0] div_acc;
    logic [19:0] div_step;
    logic [20:0] acc_sum;
    logic        tick;
    logic        gen_bclk;
    logic        gen_ws;
    logic [5:0]  bit_idx;
    logic [5:0]  next_bit_idx;
    logic [5:0]  half_len;
    logic [5:0]  frame_last;
    logic        bclk_s1, bclk_s2, bclk_s3;
    logic        ws_s1, ws_s2;
    logic        din_s1, din_s2;
    logic        rise_ev, fall_ev;
    logic        ws_line, din_line;
    logic        ws_r;
    logic        ws_chg;
    logic        load_pend;
    logic        load_ch;
    logic [15:0] tx_sh;
    logic [4:0]  tx_cnt;
    logic [15:0] hold_right;
    logic [15:0] next_word;
    logic        tx_pop;
    asp_stereo_s fifo_q;
    logic        fifo_valid;
    logic [15:0] rx_sh;
    logic [15:0] next_rx_sh;
    logic [4:0]  rx_cnt;
    logic        rx_started;
    logic        rx_word_ok;
    logic        left_ok;
    logic [15:0] rx_left;
    logic [7:0]  gap_cnt;

    // pin direction follows the mode; data out is never released
    assign audio_bit_clock_oe    = cfg_master;
    assign audio_word_select_oe  = cfg_master;
    assign audio_bit_clock_out   = gen_bclk;
    assign audio_word_select_out = gen_ws;

    always_comb begin
        case ({cfg_rate_44k, cfg_wide_frame})
            2'b00:   div_step = DIV_N_48_NARROW;
            2'b01:   div_step = DIV_N_48_WIDE;
            2'b10:   div_step = DIV_N_44_NARROW;
            default: div_step = DIV_N_44_WIDE;
        endcase
    end

    assign acc_sum = {1'b0, div_acc} + {1'b0, div_step};
    assign tick    = cfg_master && (acc_sum >= {1'b0, DIV_DEN});

    // phase accumulator keeps the long-run rate exact; each phase jitters
    // by one mclk cycle, well inside the duty margin
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_acc <= 20'h00000;
        end else if (!cfg_master) begin
            div_acc <= 20'h00000;
        end else if (tick) begin
            div_acc <= 20'(acc_sum - {1'b0, DIV_DEN});
        end else begin
            div_acc <= acc_sum[19:0];
        end
    end

    // toggling on every tick gives near-equal phases
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gen_bclk <= 1'b0;
        end else if (!cfg_master) begin
            gen_bclk <= 1'b0;
        end else if (tick) begin
            gen_bclk <= ~gen_bclk;
        end
    end

    assign half_len   = cfg_wide_frame ? HALF_WIDE : HALF_NARROW;
    assign frame_last = cfg_wide_frame ? LAST_WIDE : LAST_NARROW;
    assign next_bit_idx = (bit_idx >= frame_last) ? 6'h00 :
                          6'(bit_idx + 6'h01);

    // select changes on the falling edge, low half first
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bit_idx <= 6'h00;
            gen_ws  <= 1'b0;
        end else if (!cfg_master) begin
            bit_idx <= 6'h00;
            gen_ws  <= 1'b0;
        end else if (tick && gen_bclk) begin
            bit_idx <= next_bit_idx;
            gen_ws  <= (next_bit_idx >= half_len);
        end
    end

    // slave pins: two-stage synchronisers, edges taken after stage two
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bclk_s1 <= 1'b0;
            bclk_s2 <= 1'b0;
            bclk_s3 <= 1'b0;
            ws_s1   <= 1'b0;
            ws_s2   <= 1'b0;
            din_s1  <= 1'b0;
            din_s2  <= 1'b0;
        end else begin
            bclk_s1 <= audio_bit_clock_in;
            bclk_s2 <= bclk_s1;
            bclk_s3 <= bclk_s2;
            ws_s1   <= audio_word_select_in;
            ws_s2   <= ws_s1;
            din_s1  <= audio_serial_in;
            din_s2  <= din_s1;
        end
    end

    // 3.072 MHz leaves over 8 mclk cycles per phase for edge detection
    assign rise_ev  = cfg_master ? (tick && !gen_bclk) :
                      (bclk_s2 && !bclk_s3);
    assign fall_ev  = cfg_master ? (tick && gen_bclk) :
                      (!bclk_s2 && bclk_s3);
    assign ws_line  = cfg_master ? gen_ws : ws_s2;
    assign din_line = cfg_master ? audio_serial_in : din_s2;
    assign ws_chg   = rise_ev && (ws_line != ws_r);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ws_r      <= 1'b0;
            load_pend <= 1'b0;
            load_ch   <= 1'b0;
        end else begin
            if (rise_ev) ws_r <= ws_line;
            if (ws_chg) begin
                load_pend <= 1'b1;
                load_ch   <= ws_line;
            end else if (fall_ev) begin
                load_pend <= 1'b0;
            end
        end
    end

    asp_fifo2 u_tx_buf (
        .mclk      (mclk),
        .nrst      (nrst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (fifo_valid),
        .out_ready (tx_pop),
        .out_data  (fifo_q)
    );

    // a frame is taken whole at the start of its left half, so the two
    // channels of one sample never split across frames
    assign tx_pop = fall_ev && load_pend && !load_ch;
    always_comb begin
        if (load_ch) begin
            next_word = hold_right;
        end else if (fifo_valid) begin
            next_word = fifo_q.left;
        end else begin
            next_word = 16'h0000;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_sh            <= 16'h0000;
            tx_cnt           <= WORD_BITS_C;
            hold_right       <= 16'h0000;
            audio_serial_out <= 1'b0;
            tx_underrun      <= 1'b0;
        end else begin
            tx_underrun <= tx_pop && !fifo_valid;
            if (tx_pop) begin
                hold_right <= fifo_valid ? fifo_q.right : 16'h0000;
            end
            if (fall_ev) begin
                if (load_pend) begin
                    audio_serial_out <= next_word[15];
                    tx_sh            <= {next_word[14:0], 1'b0};
                    tx_cnt           <= 5'h01;
                end else if (tx_cnt < WORD_BITS_C) begin
                    audio_serial_out <= tx_sh[15];
                    tx_sh            <= {tx_sh[14:0], 1'b0};
                    tx_cnt           <= 5'(tx_cnt + 5'h01);
                end else begin
                    audio_serial_out <= 1'b0;
                end
            end
        end
    end

    assign next_rx_sh = (rx_cnt < WORD_BITS_C) ?
                        {rx_sh[14:0], din_line} : rx_sh;
    // the bit taken at the select change is the last of the old word
    assign rx_word_ok = rx_started && (rx_cnt >= WORD_LAST_C);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_sh      <= 16'h0000;
            rx_cnt     <= RX_IDLE_CNT;
            rx_started <= 1'b0;
            left_ok    <= 1'b0;
            rx_left    <= 16'h0000;
            rx_data    <= '0;
            rx_valid   <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (rise_ev) begin
                rx_sh <= next_rx_sh;
                if (ws_chg) begin
                    rx_cnt     <= 5'h00;
                    rx_started <= 1'b1;
                    if (!ws_r) begin
                        rx_left <= next_rx_sh;
                        left_ok <= rx_word_ok;
                    end else begin
                        left_ok <= 1'b0;
                        if (left_ok && rx_word_ok) begin
                            rx_data  <= '{left: rx_left, right: next_rx_sh};
                            rx_valid <= 1'b1;
                        end
                    end
                end else if (rx_cnt < WORD_BITS_C) begin
                    rx_cnt <= 5'(rx_cnt + 5'h01);
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gap_cnt <= 8'hFF;
        end else if (!cfg_master) begin
            gap_cnt <= 8'hFF;
        end else if (tick) begin
            gap_cnt <= 8'h00;
        end else if (gap_cnt != 8'hFF) begin
            gap_cnt <= 8'(gap_cnt + 8'h01);
        end
    end

    property p_slave_release;
        !cfg_master |-> !audio_bit_clock_oe && !audio_word_select_oe;
    endproperty
    a_slave_release: assert property (p_slave_release)
        else $error("slave mode still drives clock or select");

    property p_phase_min;
        tick && (gap_cnt != 8'hFF) |-> (gap_cnt + 8'h01) >= PHASE_MIN_CYC;
    endproperty
    a_phase_min: assert property (p_phase_min)
        else $error("generated clock phase too short");

    property p_ws_at_half;
        cfg_master && tick && gen_bclk && (next_bit_idx == half_len)
            |=> gen_ws && !$past(gen_ws);
    endproperty
    a_ws_at_half: assert property (p_ws_at_half)
        else $error("select did not rise at half frame");

    property p_msb_load;
        fall_ev && load_pend |=> (tx_cnt == 5'h01)
            && (audio_serial_out == $past(next_word[15]));
    endproperty
    a_msb_load: assert property (p_msb_load)
        else $error("msb not launched after select change");

    property p_pad_zero;
        fall_ev && !load_pend && (tx_cnt >= WORD_BITS_C)
            |=> !audio_serial_out;
    endproperty
    a_pad_zero: assert property (p_pad_zero)
        else $error("extra bit period not zero");

    property p_out_on_fall;
        $changed(audio_serial_out) |-> $past(fall_ev);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("data out changed away from falling edge");

    property p_left_capture;
        ws_chg && !ws_r |=> rx_left == $past(next_rx_sh);
    endproperty
    a_left_capture: assert property (p_left_capture)
        else $error("left word not captured at select rise");

    property p_rx_count;
        rx_cnt <= WORD_BITS_C;
    endproperty
    a_rx_count: assert property (p_rx_count)
        else $error("receive bit count beyond word length");

    property p_rx_pair;
        rx_valid |-> $past(ws_chg) && $past(ws_r) && $past(left_ok);
    endproperty
    a_rx_pair: assert property (p_rx_pair)
        else $error("sample emitted without a left and right pair");

endmodule : asp_port

`default_nettype wire

/* File: testbench/asp_codec_model.sv */
`timescale 1ns/1ps
`default_nettype none

// far-side codec: makes clock and select only while the device is slave
module asp_codec_model (
    input  wire logic                 gen_en,
    input  wire logic [15:0]          half_ns,
    input  wire logic [7:0]           frame_bits,
    input  wire logic                 bit_clock,
    input  wire logic                 word_select,
    input  wire logic                 dev_data,
    output var  logic                 clk_drive,
    output var  logic                 ws_drive,
    output var  logic                 data_drive,
    output var  logic [15:0]          frame_cnt,
    output var  asp_pkg::asp_stereo_s frame_word,
    output var  logic [7:0]           half_bits,
    output var  logic [15:0]          extra_bad,
    output var  asp_pkg::asp_stereo_s sent_frame,
    output var  logic                 sent_ok
);
    import asp_pkg::*;
    logic [15:0] rx_sh;
    int          rx_cnt;
    int          tx_idx;
    logic        rx_ws;
    logic        tx_ws;
    logic        tx_full;
    asp_stereo_s tx_frame;

    initial begin
        {clk_drive, ws_drive, data_drive, rx_ws, tx_ws, tx_full} = '0;
        {frame_cnt, frame_word, half_bits, extra_bad} = '0;
        {sent_frame, sent_ok, rx_sh, tx_frame} = '0;
        rx_cnt = 0;
        tx_idx = 99;
        forever begin
            wait (gen_en === 1'b1);
            // whole frames only, back to back, so the clock stops only at a frame end
            for (int k = 0; k < int'(frame_bits); k++) begin
                clk_drive = 1'b0;
                ws_drive = (k >= int'(frame_bits) / 2);
                #(half_ns);
                clk_drive = 1'b1;
                #(half_ns);
            end
        end
    end

    always @(posedge bit_clock) begin
        if (rx_cnt < 16) rx_sh = {rx_sh[14:0], dev_data};
        else if (dev_data !== 1'b0) extra_bad = extra_bad + 16'h1;
        rx_cnt++;
        if (word_select !== rx_ws) begin
            half_bits = 8'(rx_cnt);
            if (rx_ws) begin
                frame_word.right = rx_sh;
                frame_cnt = frame_cnt + 16'h1;
            end else begin
                frame_word.left = rx_sh;
            end
            rx_cnt = 0;
            rx_ws = word_select;
        end
    end

    always @(posedge bit_clock) begin
        if (word_select !== tx_ws) begin
            tx_ws = word_select;
            tx_idx = 0;
            if (!tx_ws) begin
                sent_ok = tx_full;
                sent_frame = tx_frame;
                tx_frame = asp_stereo_s'($urandom);
                tx_full = 1'b1;
            end
        end else begin
            tx_idx++;
        end
    end

    // bits past the sixteenth are noise that the device must ignore
    always @(negedge bit_clock) begin
        if (tx_idx < 16)
            data_drive = tx_ws ? tx_frame.right[15 - tx_idx]
                               : tx_frame.left[15 - tx_idx];
        else
            data_drive = 1'($urandom);
    end
endmodule : asp_codec_model

`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
    import asp_pkg::*;
    logic        mclk, nrst, cfg_master, cfg_rate_44k, cfg_wide_frame;
    logic        bclk_out, bclk_oe, ws_out, ws_oe, sd_out, sd_in;
    logic        tx_valid, tx_ready, tx_underrun, rx_valid;
    logic        gen_en, sent_ok, p_clk, p_ws, last_b;
    logic [15:0] half_ns, frame_cnt, extra_bad;
    logic [7:0]  frame_bits, half_bits;
    asp_stereo_s tx_data, rx_data, frame_word, sent_frame;
    asp_stereo_s expq[$];
    asp_stereo_s rxq[$];
    asp_stereo_s corner[3] = '{32'h8000_0001, 32'hFFFF_FFFF, 32'h0001_8000};
    int          err_total, compares, underruns, rx_seen;
    int          run, prev_run, edges;
    wire logic   bclk = bclk_oe ? bclk_out : p_clk;
    wire logic   ws = ws_oe ? ws_out : p_ws;

    asp_port i_asp_port (
        .mclk(mclk), .nrst(nrst), .cfg_master(cfg_master),
        .cfg_rate_44k(cfg_rate_44k), .cfg_wide_frame(cfg_wide_frame),
        .audio_bit_clock_in(bclk), .audio_bit_clock_out(bclk_out),
        .audio_bit_clock_oe(bclk_oe), .audio_word_select_in(ws),
        .audio_word_select_out(ws_out), .audio_word_select_oe(ws_oe),
        .audio_serial_out(sd_out), .audio_serial_in(sd_in),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .tx_underrun(tx_underrun), .rx_valid(rx_valid), .rx_data(rx_data)
    );

    asp_codec_model i_asp_codec_model (
        .gen_en(gen_en), .half_ns(half_ns), .frame_bits(frame_bits),
        .bit_clock(bclk), .word_select(ws), .dev_data(sd_out),
        .clk_drive(p_clk), .ws_drive(p_ws), .data_drive(sd_in),
        .frame_cnt(frame_cnt), .frame_word(frame_word),
        .half_bits(half_bits), .extra_bad(extra_bad),
        .sent_frame(sent_frame), .sent_ok(sent_ok)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        if (err_total == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // the accumulator may stretch any period by one cycle, never more
    function automatic logic per_ok(input int per);
        real e;
        e = real'(MCLK_HZ) / ((cfg_rate_44k ? FS_44K_HZ : FS_48K_HZ)
            * (cfg_wide_frame ? BITS_WIDE : BITS_NARROW));
        return real'(per) > e - 1.0 && real'(per) < e + 1.0;
    endfunction : per_ok

    always @(frame_cnt) rxq.push_back(frame_word);

    always @(negedge mclk) begin
        if (nrst === 1'b1) begin
            if (tx_underrun === 1'b1) underruns++;
            if (rx_valid === 1'b1) begin
                rx_seen++;
                if (sent_ok) check(rx_data, sent_frame);
            end
            if (cfg_master) begin
                run++;
                if (bclk_out !== last_b) begin
                    edges++;
                    if (edges > 1)
                        check(32'(run >= PHASE_MIN_CYC), 1);
                    if (edges > 2 && bclk_out)
                        check(32'(per_ok(run + prev_run)), 1);
                    prev_run = run;
                    run = 0;
                    last_b = bclk_out;
                end
            end
        end else begin
            run = 0;
            edges = 0;
            last_b = 1'b0;
        end
    end

    // holds valid and data until the design shows ready
    task automatic push(input asp_stereo_s s);
        int n;
        tx_valid = 1'b1;
        tx_data = s;
        for (n = 0; n < 5000 && tx_ready !== 1'b1; n++) @(negedge mclk);
        if (n == 5000) begin
            check(0, 1);
            wrap_up();
        end
        @(negedge mclk);
        expq.push_back(s);
    endtask : push

    task automatic run_mode(input logic m, r, w, input int hns, fb);
        int f0, k, i;
        @(negedge mclk);
        cfg_master = m;
        cfg_rate_44k = r;
        cfg_wide_frame = w;
        half_ns = 16'(hns);
        frame_bits = 8'(fb);
        gen_en = !m;
        nrst = 1'b0;
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        check({30'h0, bclk_oe, ws_oe}, {30'h0, m, m});
        rxq.delete();
        expq.delete();
        for (k = 0; k < 8; k++) begin
            push(k < 3 ? corner[k] : asp_stereo_s'($urandom | 32'h1));
            if (k == 1 && m) check(32'(tx_ready), 0);
        end
        tx_valid = 1'b0;
        f0 = frame_cnt;
        for (k = 0; k < 8000 && frame_cnt - f0 < 5; k++) @(negedge mclk);
        if (frame_cnt - f0 < 5) begin
            check(0, 1);
            wrap_up();
        end
        i = 0;
        while (i < rxq.size() && rxq[i] === 32'h0) i++;
        if (rxq.size() < i + 9) begin
            check(32'(rxq.size()), 32'(i + 9));
        end else begin
            for (k = 0; k < 8; k++) check(rxq[i + k], expq[k]);
            check(rxq[i + 8], 32'h0);
        end
        check(32'(half_bits), 32'(fb / 2));
    endtask : run_mode

    initial begin
        void'($urandom(32'hCC07A102));
        nrst = 1'b0;
        cfg_master = 1'b1;
        cfg_rate_44k = 1'b0;
        cfg_wide_frame = 1'b0;
        tx_valid = 1'b0;
        tx_data = '0;
        gen_en = 1'b0;
        half_ns = 16'd163;
        frame_bits = 8'd32;
        last_b = 1'b0;
        run_mode(1'b1, 1'b0, 1'b0, 0, 32);
        run_mode(1'b1, 1'b0, 1'b1, 0, 50);
        run_mode(1'b1, 1'b1, 1'b0, 0, 32);
        run_mode(1'b1, 1'b1, 1'b1, 0, 50);
        run_mode(1'b0, 1'b0, 1'b0, 163, 32);
        run_mode(1'b0, 1'b0, 1'b0, 250, 40);
        check(32'(extra_bad), 0);
        check(32'(underruns != 0), 1);
        check(32'(rx_seen != 0), 1);
        wrap_up();
    end
endmodule : tb

`default_nettype wire
